// ---- rtl/tmr_pkg.sv ----
// constants shared by the interval / time-base timer and its clock output
//
// Functional notes
// [R01] output-select register bits 7..1 read as one; writes to them ignored
// [R02] source bit 0 drives divided timer clock out; 1 drives raw subclock
// [R03] output-select register resets to FE, source bit zero
// [R04] mode bit clear: 8-bit interval timer on system prescaler taps
// [R05] reset clears counter and mode bit, counting starts straight away
// [R06] interval mode: three rate bits pick one of eight system taps
// [R07] counter at FF, next tick overflows and sets the overflow flag
// [R08] interrupt request only while overflow enable bit is one
// [R09] counter wraps to 00 and keeps counting, overflow every 256 ticks
// [R10] mode bit set: count subclock prescaler, two bits pick the period
// [R11] time-base mode, clear bit set: counter and subclock prescaler cleared
// [R12] clock pin carries the clock only while port pin bit is one
// [R13] three select bits plus source bit give nine output clocks
// [R14] system clock divided outputs only in active and sleep modes
// [R15] subclock divided outputs in active, sleep, watch, subactive, subsleep
// [R16] raw subclock output in every mode except during reset
// [R17] interval runs active/sleep only; time base halts in standby only
// [R18] subclock ticks pass a synchroniser; one system cycle error allowed
// [R19] mode bit writes ignored while module standby bit is zero
// [R20] software sets the standby bit before changing the mode bit
// [R21] select codes 0xx system clock /32../4, 1xx subclock /32../4
// [R22] rate codes 0xxx system divides 8192..8, 10xx four time-base periods
// [R23] standby bit zero halts the timer; one, its reset value, releases
// [R24] counter readable in active mode, not in subactive; resets to zero
// [R25] counter steps by exactly one per enabled tick, sampled on hclk
package tmr_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_COUNT = 8'h04;
    localparam logic [7:0] ADDR_CLKSTOP = 8'h08;
    localparam logic [7:0] ADDR_OUTSRC = 8'h0C;
    localparam logic [7:0] ADDR_PORTMODE = 8'h10;
    localparam logic [7:0] ADDR_IRQREQ = 8'h14;
    localparam logic [7:0] ADDR_IRQEN = 8'h18;

    // ----------------------------------------------------------------
    // reset values and field positions
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_MODE = 8'h10;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_CLKSTOP = 8'hFF;
    localparam logic [7:0] RST_OUTSRC = 8'hFE;
    localparam logic [7:0] MODE_RSVD_MASK = 8'h10;
    localparam logic [7:0] OUTSRC_RSVD_MASK = 8'hFE;
    localparam int MODE_SEL_BIT = 3;
    localparam int RATE_BIT2 = 2;
    localparam int OUT_SEL_LSB = 5;
    localparam int STANDBY_BIT = 0;
    localparam int OUTSRC_BIT = 0;
    localparam int PIN_FUNC_BIT = 0;
    localparam int OVF_FLAG_BIT = 0;
    localparam int OVF_EN_BIT = 0;

    // ----------------------------------------------------------------
    // prescaler widths and taps (log2 of the divide)
    // ----------------------------------------------------------------
    localparam int SYS_PS_W = 13;
    localparam int SUB_PS_W = 8;
    localparam logic [3:0] SYS_TAP [8] = '{4'd13, 4'd12, 4'd11, 4'd9,
                                           4'd8, 4'd7, 4'd5, 4'd3};
    // subclock taps for 128, 64, 32, 4 cycle periods, 3.906 to 0.122 ms at 32.768 kHz
    localparam logic [3:0] SUB_TAP [4] = '{4'd7, 4'd6, 4'd5, 4'd2};

    // ----------------------------------------------------------------
    // chip power modes, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [5:0] {
        PM_ACTIVE = 6'h01,
        PM_SLEEP = 6'h02,
        PM_WATCH = 6'h04,
        PM_SUBACTIVE = 6'h08,
        PM_SUBSLEEP = 6'h10,
        PM_STANDBY = 6'h20
    } power_mode_t;

endpackage : tmr_pkg

// ---- rtl/tmr_sync.sv ----
// two-stage synchroniser for a level that arrives from another clock
`timescale 1ns/1ps
module tmr_sync (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // level in and synchronised level out
    input wire logic async_in,
    output logic sync_out
);
    logic meta;

    // first stage is read by the second stage only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule : tmr_sync

// ---- rtl/tmr_prescaler.sv ----
// free-running binary prescaler with a step enable and a synchronous clear
`timescale 1ns/1ps
module tmr_prescaler #(
    parameter int WIDTH = 13
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // control
    input wire logic step,
    input wire logic clear,
    // prescaler value
    output logic [WIDTH-1:0] value
);
    initial begin
        if (WIDTH < 5 || WIDTH > 16) begin
            $error("tmr_prescaler: WIDTH must be 5..16");
        end
    end

    // clear takes priority so a held clear keeps the stage at zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            value <= '0;
        end else if (clear) begin
            value <= '0;
        end else if (step) begin
            value <= value + WIDTH'(1);
        end
    end
endmodule : tmr_prescaler

// ---- rtl/tmr_timebase.sv ----
// 8-bit interval / time-base timer with clock output and AHB-Lite registers
//
// Decided for this implementation: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module tmr_timebase
    import tmr_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // chip power state, from the same clock domain
    input wire logic [5:0] power_mode,
    // subclock pin, asynchronous to hclk
    input wire logic sub_clk,
    // outputs
    output logic clk_out_pin,
    output logic overflow_irq
);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] timer_mode_reg;
    logic [7:0] count_value;
    logic [7:0] clock_stop_reg;
    logic [7:0] clock_out_source_select;
    logic [7:0] port_mode_reg;
    logic [7:0] irq_request_reg;
    logic [7:0] irq_enable_reg;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // true when every bit below tap n is one: the next step carries into n
    function automatic logic tap_carry(input logic [15:0] v,
                                       input logic [3:0] n);
        logic [15:0] mask;
        mask = (16'h0001 << n) - 16'h0001;
        return (v & mask) == mask;
    endfunction : tap_carry

    function automatic logic in_mode(input logic [5:0] pm,
                                     input power_mode_t m);
        return (pm & m) != 6'h00;
    endfunction : in_mode

    // ----------------------------------------------------------------
    // AHB-Lite address phase capture
    // ----------------------------------------------------------------
    logic dp_write;
    logic [7:0] dp_addr;
    wire addr_valid = hsel && hready && htrans[1];
    wire wr_mode = dp_write && dp_addr == ADDR_MODE;
    wire wr_clkstop = dp_write && dp_addr == ADDR_CLKSTOP;
    wire wr_outsrc = dp_write && dp_addr == ADDR_OUTSRC;
    wire wr_portmode = dp_write && dp_addr == ADDR_PORTMODE;
    wire wr_irqreq = dp_write && dp_addr == ADDR_IRQREQ;
    wire wr_irqen = dp_write && dp_addr == ADDR_IRQEN;
    wire [7:0] wbyte = hwdata[7:0];

    // the slave never stalls and never errors; writes land in the data phase
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
        end else begin
            dp_write <= addr_valid && hwrite;
            dp_addr <= haddr;
        end
    end

    // ----------------------------------------------------------------
    // power and standby qualification
    // ----------------------------------------------------------------
    wire mode_tb = timer_mode_reg[MODE_SEL_BIT];
    wire rate_clear = mode_tb && timer_mode_reg[RATE_BIT2];
    wire released = clock_stop_reg[STANDBY_BIT];                 // [R23]
    wire pm_fast = in_mode(power_mode, PM_ACTIVE)
                || in_mode(power_mode, PM_SLEEP);
    wire pm_standby = in_mode(power_mode, PM_STANDBY);
    wire pm_subact = in_mode(power_mode, PM_SUBACTIVE);
    // interval counting only on the fast clock; time base survives all
    // but standby and module standby
    wire count_run = released
                  && (mode_tb ? !pm_standby : pm_fast);           // [R17]

    // ----------------------------------------------------------------
    // subclock synchroniser and edge detect
    // ----------------------------------------------------------------
    logic sub_lvl;
    logic sub_lvl_d;

    tmr_sync u_sub_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(sub_clk),
        .sync_out(sub_lvl)
    );

    // edge taken after the second stage; costs up to one hclk of jitter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sub_lvl_d <= 1'b0;
        end else begin
            sub_lvl_d <= sub_lvl;
        end
    end
    wire sub_tick = sub_lvl && !sub_lvl_d;                        // [R18]

    // ----------------------------------------------------------------
    // prescalers
    // ----------------------------------------------------------------
    logic [SYS_PS_W-1:0] sys_prescaler;
    logic [SUB_PS_W-1:0] sub_prescaler;
    // the system prescaler stops with the fast clock
    wire sys_step = pm_fast;

    tmr_prescaler #(
        .WIDTH(SYS_PS_W)
    ) u_sys_ps (
        .hclk(hclk),
        .hresetn(hresetn),
        .step(sys_step),
        .clear(1'b0),
        .value(sys_prescaler)
    );

    tmr_prescaler #(
        .WIDTH(SUB_PS_W)
    ) u_sub_ps (
        .hclk(hclk),
        .hresetn(hresetn),
        .step(sub_tick && !pm_standby),
        .clear(rate_clear),                                       // [R11]
        .value(sub_prescaler)
    );

    // ----------------------------------------------------------------
    // count source selection
    // ----------------------------------------------------------------
    wire [2:0] rate_code = timer_mode_reg[2:0];
    wire [3:0] sys_tap = SYS_TAP[rate_code];                      // [R06] [R22]
    wire [3:0] sub_tap = SUB_TAP[rate_code[1:0]];                 // [R10] [R22]
    wire sys_tick = sys_step
                 && tap_carry(16'(sys_prescaler), sys_tap);       // [R04]
    wire tb_tick = sub_tick && !pm_standby
                && tap_carry(16'(sub_prescaler), sub_tap);
    wire count_tick = count_run && !rate_clear
                   && (mode_tb ? tb_tick : sys_tick);
    wire overflow = count_tick && count_value == 8'hFF;           // [R07]

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    // one step per qualified tick; wraps to zero on overflow
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_value <= RST_COUNT;                             // [R05]
        end else if (rate_clear) begin
            count_value <= 8'h00;                                 // [R11]
        end else if (count_tick) begin
            count_value <= count_value + 8'h01;                   // [R09] [R25]
        end
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    // mode bit is locked while the module sits in module standby
    wire next_mode_sel = (wr_mode && released) ? wbyte[MODE_SEL_BIT]
                       : timer_mode_reg[MODE_SEL_BIT];            // [R19]
    wire [7:0] next_mode = wr_mode
        ? ((wbyte & 8'hE7) | MODE_RSVD_MASK
           | {4'h0, next_mode_sel, 3'h0})
        : timer_mode_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_mode_reg <= RST_MODE;                           // [R05]
            clock_stop_reg <= RST_CLKSTOP;                        // [R23]
            clock_out_source_select <= RST_OUTSRC;                // [R03]
            port_mode_reg <= 8'h00;
            irq_enable_reg <= 8'h00;
        end else begin
            timer_mode_reg <= next_mode;
            if (wr_clkstop) begin
                clock_stop_reg <= wbyte;
            end
            if (wr_outsrc) begin
                clock_out_source_select <= OUTSRC_RSVD_MASK
                                         | (wbyte & 8'h01);       // [R01]
            end
            if (wr_portmode) begin
                port_mode_reg <= wbyte & 8'h01;
            end
            if (wr_irqen) begin
                irq_enable_reg <= wbyte & 8'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // overflow request flag
    // ----------------------------------------------------------------
    // software clears by writing zero; an overflow in the same cycle wins
    wire flag_clr = wr_irqreq && !wbyte[OVF_FLAG_BIT];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_request_reg <= 8'h00;
        end else if (overflow) begin
            irq_request_reg <= 8'h01;                             // [R07]
        end else if (flag_clr) begin
            irq_request_reg <= 8'h00;
        end
    end

    assign overflow_irq = irq_request_reg[OVF_FLAG_BIT]
                       && irq_enable_reg[OVF_EN_BIT];             // [R08]

    // ----------------------------------------------------------------
    // clock output selection
    // ----------------------------------------------------------------
    wire [1:0] out_idx = timer_mode_reg[OUT_SEL_LSB +: 2];
    // divide by 32,16,8,4 is prescaler bit 4,3,2,1
    wire [2:0] div_bit = 3'(3'd4 - {1'b0, out_idx});
    wire sys_div = sys_prescaler[div_bit] && pm_fast;             // [R14]
    wire sub_div = sub_prescaler[div_bit] && !pm_standby;         // [R15]
    wire timer_clk = timer_mode_reg[7] ? sub_div : sys_div;       // [R21]
    wire sel_clk = clock_out_source_select[OUTSRC_BIT]
                 ? sub_lvl : timer_clk;                           // [R02] [R13] [R16]
    wire next_pin = port_mode_reg[PIN_FUNC_BIT] && sel_clk;       // [R12]

    // registered pin so the output cannot glitch on select changes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_out_pin <= 1'b0;
        end else begin
            clk_out_pin <= next_pin;
        end
    end

    // ----------------------------------------------------------------
    // read data, captured in the address phase
    // ----------------------------------------------------------------
    // counter is not visible on the bus while the core runs from subclock
    wire [7:0] count_rd = pm_subact ? 8'h00 : count_value;        // [R24]
    wire [7:0] rd_byte =
        (haddr == ADDR_MODE) ? timer_mode_reg :
        (haddr == ADDR_COUNT) ? count_rd :
        (haddr == ADDR_CLKSTOP) ? clock_stop_reg :
        (haddr == ADDR_OUTSRC) ? clock_out_source_select :        // [R01]
        (haddr == ADDR_PORTMODE) ? port_mode_reg :
        (haddr == ADDR_IRQREQ) ? irq_request_reg :
        (haddr == ADDR_IRQEN) ? irq_enable_reg : 8'h00;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_valid && !hwrite) begin
            hrdata <= {24'h00_0000, rd_byte};
        end
    end

endmodule : tmr_timebase

// ---- testbench/tmr_sub_clk_model.sv ----
// free-running subclock source standing in for the watch crystal
`timescale 1ns/1ps
module tmr_sub_clk_model #(
    parameter realtime HALF_NS = 61.0
) (
    // crystal output
    output logic sub_clk
);
    // the crystal never stops; odd start offset keeps it off the hclk grid
    initial begin
        sub_clk = 1'b0;
        #(HALF_NS * 0.37);
        forever #(HALF_NS) sub_clk = ~sub_clk;
    end
endmodule : tmr_sub_clk_model

// ---- testbench/tmr_timebase_asserts.sv ----
// port-level checks on the timer's register bus and clock output
`timescale 1ns/1ps
module tmr_timebase_asserts
    import tmr_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    // chip side
    input wire logic [5:0] power_mode,
    input wire logic sub_clk,
    input wire logic clk_out_pin,
    input wire logic overflow_irq
);
    // ----------------------------------------------------------------
    // shadow of the settings, rebuilt from bus traffic
    // ----------------------------------------------------------------
    logic rd_q, wr_q, pin_en, src_sel, irq_en;
    logic [7:0] addr_q;
    logic [5:0] pm_q;
    logic [2:0] sel_q, calm;
    wire taken = hsel && hready && htrans[1];
    wire wr_ph = wr_q && hready;
    // any write or mode change restarts the settle count
    wire cfg_chg = wr_ph || (power_mode != pm_q);

    // shadow registers follow completed write data phases
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {rd_q, wr_q, pin_en, src_sel, irq_en} <= 5'h00;
            addr_q <= 8'h00;
            pm_q <= 6'h01;
            sel_q <= 3'h0;
            calm <= 3'h0;
        end else begin
            rd_q <= taken && !hwrite;
            wr_q <= taken && hwrite;
            addr_q <= taken ? haddr : addr_q;
            pm_q <= power_mode;
            calm <= cfg_chg ? 3'h0 : calm + {2'h0, calm != 3'h7};
            if (wr_ph && addr_q == ADDR_PORTMODE) pin_en <= hwdata[0];
            if (wr_ph && addr_q == ADDR_OUTSRC) src_sel <= hwdata[0];
            if (wr_ph && addr_q == ADDR_IRQEN) irq_en <= hwdata[0];
            if (wr_ph && addr_q == ADDR_MODE) sel_q <= hwdata[7:5];
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    outsrc_ones_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        rd_q && addr_q == ADDR_OUTSRC |-> hrdata[31:1] == 31'h0000007F)
        else $error("output select reserved bits not ones");
    count_subact_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        rd_q && addr_q == ADDR_COUNT && pm_q == PM_SUBACTIVE
        |-> hrdata == 32'h0) else $error("count readable in subactive");
    rdata_hold_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !rd_q |-> $stable(hrdata)) else $error("read data moved");
    irq_gate_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !irq_en |-> !overflow_irq) else $error("interrupt while disabled");
    pin_gate_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !pin_en && !$past(pin_en) |-> !clk_out_pin)
        else $error("clock pin active while disabled");
    raw_follow_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        src_sel && pin_en && calm == 3'h7 && $rose(sub_clk)
        |-> ##[2:6] clk_out_pin) else $error("raw subclock not on pin");
    sysdiv_quiet_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !src_sel && !sel_q[2] && calm == 3'h7
        && !(pm_q inside {PM_ACTIVE, PM_SLEEP}) |-> !clk_out_pin)
        else $error("system divide out in low power");
    div4_toggle_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        calm == 3'h7 && pin_en && !src_sel && sel_q == 3'h3
        && pm_q == PM_ACTIVE |-> clk_out_pin != $past(clk_out_pin, 2))
        else $error("divide by four output wrong");
endmodule : tmr_timebase_asserts

bind tmr_timebase tmr_timebase_asserts chk (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hready, .hwdata, .hrdata, .power_mode, .sub_clk,
    .clk_out_pin, .overflow_irq);

// ---- testbench/tmr_timebase_test.sv ----
// self-checking bench for the interval / time-base timer
`timescale 1ns/1ps
module tmr_timebase_test
    import tmr_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic sub_clk, clk_out_pin, overflow_irq;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, q0, q1;
    logic [5:0] power_mode;
    wire hready = hreadyout;
    int error_cnt = 0, checked = 0, t, n;
    realtime t0;
    localparam logic [7:0] RA [7] = '{ADDR_MODE, ADDR_COUNT, ADDR_CLKSTOP,
        ADDR_OUTSRC, ADDR_PORTMODE, ADDR_IRQREQ, ADDR_IRQEN};
    localparam logic [7:0] RV [7] = '{RST_MODE, RST_COUNT, RST_CLKSTOP,
        RST_OUTSRC, 8'h00, 8'h00, 8'h00};

    tmr_timebase dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .power_mode(power_mode),
        .sub_clk(sub_clk), .clk_out_pin(clk_out_pin),
        .overflow_irq(overflow_irq));
    tmr_sub_clk_model #(.HALF_NS(61.0)) sub_src (.sub_clk(sub_clk));

    // ----------------------------------------------------------------
    // bus tasks and checks
    // ----------------------------------------------------------------
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, {24'h0, d}, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask : rd
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            error_cnt++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic flag_is(input logic e);
        #1;
        check({31'h0, overflow_irq}, {31'h0, e});
    endtask : flag_is
    function automatic logic [31:0] in_rng(input int v, input int lo,
                                           input int hi);
        return {31'h0, (v >= lo) && (v <= hi)};
    endfunction : in_rng
    // count pin changes after a short settle, sampled clear of the edge
    task automatic toggles(input int cyc);
        logic last;
        repeat (6) @(posedge hclk);
        #1;
        last = clk_out_pin;
        t = 0;
        repeat (cyc) begin
            @(posedge hclk);
            #1;
            if (clk_out_pin !== last) t++;
            last = clk_out_pin;
        end
    endtask : toggles
    // bounded wait; a miss shows up in the flag check that follows
    task automatic wait_irq;
        n = 0;
        while (overflow_irq !== 1'b1 && n < 2300) begin
            @(posedge hclk);
            #1;
            n++;
        end
    endtask : wait_irq
    task automatic give_verdict;
        $display("mismatches %0d comparisons %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    // ----------------------------------------------------------------
    // clock, watchdog and test sequence
    // ----------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    initial begin
        #160000;
        error_cnt++;
        give_verdict;
    end
    initial begin
        {hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
        hsize = 3'h2;
        power_mode = PM_ACTIVE;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(RA[i], q0);
            check(q0, {24'h0, RV[i]});
        end
        wr(ADDR_OUTSRC, 8'h00);
        rd(ADDR_OUTSRC, q0);
        check(q0, 32'hFE);
        wr(ADDR_OUTSRC, 8'hFF);
        rd(ADDR_OUTSRC, q0);
        check(q0, 32'hFF);
        wr(ADDR_OUTSRC, 8'h00);
        wr(8'h1C, 8'h5A);
        rd(8'h1C, q0);
        check(q0, 32'h0);
        check({31'h0, hresp}, 32'h0);
        // interval mode on the divide-by-8 tap
        wr(ADDR_MODE, 8'h07);
        rd(ADDR_COUNT, q0);
        repeat (80) @(posedge hclk);
        rd(ADDR_COUNT, q1);
        check(in_rng(int'(q1[7:0] - q0[7:0]), 9, 12), 1);
        wr(ADDR_IRQEN, 8'h01);
        wait_irq;
        flag_is(1'b1);
        t0 = $realtime;
        rd(ADDR_IRQREQ, q0);
        check(q0, 32'h1);
        wr(ADDR_IRQEN, 8'h00);
        flag_is(1'b0);
        wr(ADDR_IRQREQ, 8'h00);
        wr(ADDR_IRQEN, 8'h01);
        flag_is(1'b0);
        wait_irq;
        flag_is(1'b1);
        check(in_rng(int'(($realtime - t0) / 8.0), 2046, 2050), 1);
        // module standby freezes the count and locks the mode bit
        wr(ADDR_CLKSTOP, 8'hFE);
        rd(ADDR_COUNT, q0);
        repeat (50) @(posedge hclk);
        rd(ADDR_COUNT, q1);
        check(q1, q0);
        wr(ADDR_MODE, 8'h0F);
        rd(ADDR_MODE, q0);
        check(q0, 32'h17);
        wr(ADDR_CLKSTOP, 8'hFF);
        wr(ADDR_MODE, 8'h0B);
        rd(ADDR_MODE, q0);
        check(q0, 32'h1B);
        power_mode <= PM_WATCH;
        rd(ADDR_COUNT, q0);
        repeat (400) @(posedge hclk);
        rd(ADDR_COUNT, q1);
        check(in_rng(int'(q1[7:0] - q0[7:0]), 5, 8), 1);
        wr(ADDR_MODE, 8'h07);
        rd(ADDR_COUNT, q0);
        repeat (100) @(posedge hclk);
        rd(ADDR_COUNT, q1);
        check(q1, q0);
        wr(ADDR_MODE, 8'h0C);
        rd(ADDR_COUNT, q0);
        check(q0, 32'h0);
        wr(ADDR_MODE, 8'h0B);
        power_mode <= PM_SUBACTIVE;
        repeat (200) @(posedge hclk);
        rd(ADDR_COUNT, q0);
        check(q0, 32'h0);
        // clock output selections
        power_mode <= PM_ACTIVE;
        toggles(64);
        check(t, 0);
        wr(ADDR_PORTMODE, 8'h01);
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_MODE, 8'(c * 32 + 7));
            toggles(128);
            check(in_rng(t, (8 << c) - 1, (8 << c) + 1), 1);
        end
        @(posedge hclk) power_mode <= PM_WATCH;
        toggles(128);
        check(t, 0);
        wr(ADDR_MODE, 8'hE7);
        toggles(128);
        check(in_rng(t, 3, 5), 1);
        @(posedge hclk) power_mode <= PM_STANDBY;
        toggles(128);
        check(t, 0);
        wr(ADDR_OUTSRC, 8'h01);
        toggles(128);
        check(in_rng(t, 15, 18), 1);
        give_verdict;
    end
endmodule : tmr_timebase_test
